// ==== hw/cmpctl_pkg.sv ====
// constants shared by the comparator control block
package cmpctl_pkg;
    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] CMPCTL_IDX_CTRL_STATUS = 8'h50;
    localparam logic [7:0] CMPCTL_IDX_CONV_CTRL_B = 8'h7b;
    localparam logic [7:0] CMPCTL_IDX_PIN_DISABLE = 8'h7f;
    // ==========================================================
    // control/status field positions
    localparam int CMPCTL_BIT_DISABLE = 7;
    localparam int CMPCTL_BIT_BANDGAP = 6;
    localparam int CMPCTL_BIT_RESULT = 5;
    localparam int CMPCTL_BIT_FLAG = 4;
    localparam int CMPCTL_BIT_IRQ_EN = 3;
    localparam int CMPCTL_BIT_CAPTURE = 2;
    localparam int CMPCTL_BIT_MODE_HI = 1;
    localparam int CMPCTL_BIT_MODE_LO = 0;
    // converter control b field positions
    localparam int CMPCTL_BIT_BORROW = 6;
    localparam int CMPCTL_BIT_CHAN_HI = 3;
    // pin disable field positions
    localparam int CMPCTL_BIT_NEG_OFF = 1;
    localparam int CMPCTL_BIT_POS_OFF = 0;
    // ==========================================================
    // reset values
    localparam logic [7:0] CMPCTL_RST_CTRL = 8'h00;
    localparam logic [7:0] CMPCTL_RST_CONV_B = 8'h00;
    localparam logic [7:0] CMPCTL_RST_PIN = 8'h00;
    // ==========================================================
    // event mode encodings
    typedef enum logic [1:0] {
        CMPCTL_MODE_TOGGLE = 2'b00,
        CMPCTL_MODE_RSVD = 2'b01,
        CMPCTL_MODE_FALL = 2'b10,
        CMPCTL_MODE_RISE = 2'b11
    } cmpctl_mode_t;
endpackage : cmpctl_pkg

// ==== hw/cmpctl_top.sv ====
// comparator control logic with avalon-mm register slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
module cmpctl_top
    import cmpctl_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic clk,
    input wire logic arst_n,
    // avalon-mm slave, byte addresses
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // analog side
    input wire logic comparator_raw,
    output logic comparator_power_off,
    output logic positive_from_bandgap,
    output logic negative_from_mux,
    output logic [3:0] negative_channel,
    // converter side
    input wire logic converter_enable,
    input wire logic [2:0] channel_low_bits,
    output logic channel_high_bit,
    output logic [2:0] converter_trigger_select,
    // cpu interrupt side
    input wire logic global_irq_enable,
    input wire logic irq_vector_taken,
    output logic irq_request,
    // timer capture front end
    output logic capture_input,
    output logic capture_route_enable,
    // digital pin inputs
    input wire logic positive_input_pin,
    input wire logic negative_input_pin,
    output logic positive_pin_read,
    output logic negative_pin_read,
    output logic positive_pin_buffer_off,
    output logic negative_pin_buffer_off
);
    // the register decoder takes the word index from address bits 9:2
    if (ADDR_W < 10) begin : g_addr_w_check
        $error("cmpctl_top: ADDR_W must be at least 10");
    end


    // ==========================================================
    // bus slave: one wait cycle, then a one-cycle answer
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic req;
    logic accept;
    logic [7:0] word_idx;
    logic wr_lane0;

    assign req = read | write;
    assign accept = req & ~wait_reg;
    assign word_idx = address[9:2];
    assign wr_lane0 = accept & write & byteenable[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg <= 1'b1;
        end else if (req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // ==========================================================
    // registers
    logic disable_reg;
    logic bandgap_reg;
    logic flag_reg;
    logic irq_en_reg;
    logic capture_reg;
    logic [1:0] mode_reg;
    logic borrow_reg;
    logic chan_hi_reg;
    logic [2:0] trig_sel_reg;
    logic pos_off_reg;
    logic neg_off_reg;
    logic wr_ctrl;
    logic wr_conv;
    logic wr_pin;

    assign wr_ctrl = wr_lane0 && (word_idx == CMPCTL_IDX_CTRL_STATUS);
    assign wr_conv = wr_lane0 && (word_idx == CMPCTL_IDX_CONV_CTRL_B);
    assign wr_pin = wr_lane0 && (word_idx == CMPCTL_IDX_PIN_DISABLE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disable_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_DISABLE];
            bandgap_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_BANDGAP];
            irq_en_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_IRQ_EN];
            capture_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_CAPTURE];
            mode_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_MODE_HI:CMPCTL_BIT_MODE_LO];
        end else if (wr_ctrl) begin
            disable_reg <= writedata[CMPCTL_BIT_DISABLE];
            bandgap_reg <= writedata[CMPCTL_BIT_BANDGAP];
            irq_en_reg <= writedata[CMPCTL_BIT_IRQ_EN];
            capture_reg <= writedata[CMPCTL_BIT_CAPTURE];
            mode_reg <= writedata[CMPCTL_BIT_MODE_HI:CMPCTL_BIT_MODE_LO];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            borrow_reg <= CMPCTL_RST_CONV_B[CMPCTL_BIT_BORROW];
            chan_hi_reg <= CMPCTL_RST_CONV_B[CMPCTL_BIT_CHAN_HI];
            trig_sel_reg <= CMPCTL_RST_CONV_B[2:0];
        end else if (wr_conv) begin
            borrow_reg <= writedata[CMPCTL_BIT_BORROW];
            chan_hi_reg <= writedata[CMPCTL_BIT_CHAN_HI];
            trig_sel_reg <= writedata[2:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_off_reg <= CMPCTL_RST_PIN[CMPCTL_BIT_POS_OFF];
            neg_off_reg <= CMPCTL_RST_PIN[CMPCTL_BIT_NEG_OFF];
        end else if (wr_pin) begin
            pos_off_reg <= writedata[CMPCTL_BIT_POS_OFF];
            neg_off_reg <= writedata[CMPCTL_BIT_NEG_OFF];
        end
    end

    // ==========================================================
    // result synchroniser and event detection
    logic sync1_reg;
    logic result_reg;
    logic prev_reg;
    logic rise;
    logic fall;
    logic event_hit;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            result_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= comparator_raw;
            result_reg <= sync1_reg;
            prev_reg <= result_reg;
        end
    end

    assign rise = result_reg & ~prev_reg;
    assign fall = ~result_reg & prev_reg;

    // the reserved code matches nothing so a stray write cannot fire
    always_comb begin
        unique case (cmpctl_mode_t'(mode_reg))
            CMPCTL_MODE_TOGGLE: event_hit = rise | fall;
            CMPCTL_MODE_RSVD: event_hit = 1'b0;
            CMPCTL_MODE_FALL: event_hit = fall;
            CMPCTL_MODE_RISE: event_hit = rise;
        endcase
    end

    logic set_flag;
    logic clr_flag;
    assign set_flag = event_hit & ~disable_reg;
    assign clr_flag = irq_vector_taken | (wr_ctrl & writedata[CMPCTL_BIT_FLAG]);

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= CMPCTL_RST_CTRL[CMPCTL_BIT_FLAG];
        end else if (set_flag) begin
            flag_reg <= 1'b1;
        end else if (clr_flag) begin
            flag_reg <= 1'b0;
        end
    end

    // ==========================================================
    // registered outputs
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (word_idx)
            CMPCTL_IDX_CTRL_STATUS: rd_byte = {disable_reg, bandgap_reg, result_reg, flag_reg,
                                                irq_en_reg, capture_reg, mode_reg};
            CMPCTL_IDX_CONV_CTRL_B: rd_byte = {1'b0, borrow_reg, 2'b00, chan_hi_reg, trig_sel_reg};
            CMPCTL_IDX_PIN_DISABLE: rd_byte = {6'h00, neg_off_reg, pos_off_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (read && wait_reg) begin
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    logic power_off_reg;
    logic bg_sel_reg;
    logic neg_mux_reg;
    logic [3:0] neg_chan_reg;
    logic irq_reg;
    logic cap_in_reg;
    logic pos_rd_reg;
    logic neg_rd_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_off_reg <= 1'b0;
            bg_sel_reg <= 1'b0;
            neg_mux_reg <= 1'b0;
            neg_chan_reg <= 4'h0;
        end else begin
            power_off_reg <= disable_reg;
            bg_sel_reg <= bandgap_reg;
            neg_mux_reg <= borrow_reg & ~converter_enable;
            neg_chan_reg <= (borrow_reg & ~converter_enable) ? {chan_hi_reg, channel_low_bits} : 4'h0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
            cap_in_reg <= 1'b0;
        end else begin
            irq_reg <= flag_reg & irq_en_reg & global_irq_enable;
            cap_in_reg <= capture_reg & result_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_rd_reg <= 1'b0;
            neg_rd_reg <= 1'b0;
        end else begin
            pos_rd_reg <= positive_input_pin & ~pos_off_reg;
            neg_rd_reg <= negative_input_pin & ~neg_off_reg;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign comparator_power_off = power_off_reg;
    assign positive_from_bandgap = bg_sel_reg;
    assign negative_from_mux = neg_mux_reg;
    assign negative_channel = neg_chan_reg;
    assign channel_high_bit = chan_hi_reg;
    assign converter_trigger_select = trig_sel_reg;
    assign irq_request = irq_reg;
    assign capture_input = cap_in_reg;
    assign capture_route_enable = capture_reg;
    assign positive_pin_read = pos_rd_reg;
    assign negative_pin_read = neg_rd_reg;
    assign positive_pin_buffer_off = pos_off_reg;
    assign negative_pin_buffer_off = neg_off_reg;

    // ==========================================================
    // checks
    sequence s_raw_settles;
        $rose(comparator_raw) ##1 comparator_raw;
    endsequence

    property p_result_sync;
        @(posedge clk) disable iff (!arst_n) s_raw_settles |-> ##1 result_reg;
    endproperty
    a_result_sync: assert property (p_result_sync) else $error("result not seen two cycles after raw rise");

    property p_result_follows;
        @(posedge clk) disable iff (!arst_n) $past(arst_n) |-> ##2 (result_reg == $past(comparator_raw, 2));
    endproperty
    a_result_follows: assert property (p_result_follows) else $error("result differs from raw input");

    property p_neg_select;
        @(posedge clk) disable iff (!arst_n) ##1 (negative_from_mux == $past(borrow_reg & ~converter_enable));
    endproperty
    a_neg_select: assert property (p_neg_select) else $error("negative input select wrong");

    property p_neg_channel;
        @(posedge clk) disable iff (!arst_n)
            (borrow_reg && !converter_enable) |=> (negative_channel == {$past(chan_hi_reg), $past(channel_low_bits)});
    endproperty
    a_neg_channel: assert property (p_neg_channel) else $error("borrowed channel number wrong");

    property p_rise_flag;
        @(posedge clk) disable iff (!arst_n)
            (mode_reg == 2'b11 && rise && !disable_reg) |=> flag_reg;
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("rising event did not set flag");

    property p_reserved_quiet;
        @(posedge clk) disable iff (!arst_n) (mode_reg == 2'b01 && !flag_reg) |=> !flag_reg;
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved mode set flag");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!arst_n) (disable_reg && !flag_reg) |=> !flag_reg;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set while comparator off");

    property p_vector_clear;
        @(posedge clk) disable iff (!arst_n) (irq_vector_taken && !set_flag) |=> !flag_reg;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("flag not cleared by vector");

    property p_irq_gate;
        @(posedge clk) disable iff (!arst_n) irq_request |-> $past(flag_reg & irq_en_reg & global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables");

    property p_capture_off;
        @(posedge clk) disable iff (!arst_n) !capture_reg |=> !capture_input;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("capture driven while route off");

    property p_pin_zero;
        @(posedge clk) disable iff (!arst_n) pos_off_reg |=> !positive_pin_read;
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read not zero");
endmodule : cmpctl_top

// ==== testbench/cmpctl_analog_model.sv ====
// behavioural comparator and reference levels facing the block
`timescale 1ns/10ps
module cmpctl_analog_model #(
    parameter logic [7:0] BANDGAP_LVL = 8'hc0
) (
    input wire logic positive_from_bandgap,
    input wire logic negative_from_mux,
    input wire logic [3:0] negative_channel,
    input wire logic comparator_power_off,
    input wire logic [7:0] pos_lvl,
    input wire logic [7:0] neg_lvl,
    output logic comparator_raw
);
    // ==========================================================
    // input selection and decision
    logic [7:0] plus_lvl;
    logic [7:0] minus_lvl;
    assign plus_lvl = positive_from_bandgap ? BANDGAP_LVL : pos_lvl;
    // converter pin k sits at 16k+8, so a wrong channel changes the decision
    assign minus_lvl = negative_from_mux ? {negative_channel, 4'h8} : neg_lvl;
    // a powered-down comparator gives no decision; low is only a guess
    assign comparator_raw = comparator_power_off ? 1'b0 : (plus_lvl > minus_lvl);
endmodule : cmpctl_analog_model

// ==== testbench/test_cmpctl_top.sv ====
// self-checking bench for the comparator control block
`timescale 1ns/10ps
module test_cmpctl_top
    import cmpctl_pkg::*;
;
    // ==========================================================
    // stimulus and observation
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic converter_enable = 1'b0;
    logic global_irq_enable = 1'b0;
    logic irq_vector_taken = 1'b0;
    logic positive_input_pin = 1'b1;
    logic negative_input_pin = 1'b1;
    logic [9:0] address = 10'h000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] writedata = 32'h0;
    logic [2:0] channel_low_bits = 3'h0;
    logic [7:0] pos_lvl = 8'h00;
    logic [7:0] neg_lvl = 8'h10;
    logic [31:0] readdata, rd;
    logic waitrequest, comparator_raw, comparator_power_off, positive_from_bandgap, negative_from_mux;
    logic channel_high_bit, irq_request, capture_input, capture_route_enable;
    logic positive_pin_read, negative_pin_read, positive_pin_buffer_off, negative_pin_buffer_off;
    logic [3:0] negative_channel;
    logic [2:0] converter_trigger_select;
    int fail_count = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    cmpctl_top #(.ADDR_W(10)) cmpctl_top_i (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .comparator_raw(comparator_raw), .comparator_power_off(comparator_power_off),
        .positive_from_bandgap(positive_from_bandgap), .negative_from_mux(negative_from_mux),
        .negative_channel(negative_channel), .converter_enable(converter_enable),
        .channel_low_bits(channel_low_bits), .channel_high_bit(channel_high_bit),
        .converter_trigger_select(converter_trigger_select), .global_irq_enable(global_irq_enable),
        .irq_vector_taken(irq_vector_taken), .irq_request(irq_request), .capture_input(capture_input),
        .capture_route_enable(capture_route_enable), .positive_input_pin(positive_input_pin),
        .negative_input_pin(negative_input_pin), .positive_pin_read(positive_pin_read),
        .negative_pin_read(negative_pin_read), .positive_pin_buffer_off(positive_pin_buffer_off),
        .negative_pin_buffer_off(negative_pin_buffer_off));

    cmpctl_analog_model cmpctl_analog_model_i (.positive_from_bandgap(positive_from_bandgap),
        .negative_from_mux(negative_from_mux), .negative_channel(negative_channel),
        .comparator_power_off(comparator_power_off), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
        .comparator_raw(comparator_raw));

    // ==========================================================
    // tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // waitrequest and readdata are taken at the rising edge, before that edge's own updates land
    task automatic bus(input logic rnw, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        byteenable <= be;
        read <= rnw;
        write <= ~rnw;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b0, idx, d, 4'h1);
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp, input string what);
        bus(1'b1, idx, 8'h00, 4'hf);
        check(rd & {24'h0, mask}, {24'h0, exp}, what);
    endtask : rdchk

    // ends on a falling edge so outputs are settled when looked at
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    initial begin
        #500000;
        fail_count++;
        $display("CHECK FAILED at %0t: run timeout", $time);
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        int ch;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        check({31'h0, waitrequest}, 32'h1, "idle wait");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'hff, 8'h00, "ctrl reset");
        rdchk(CMPCTL_IDX_CONV_CTRL_B, 8'hff, 8'h00, "convb reset");
        rdchk(CMPCTL_IDX_PIN_DISABLE, 8'hff, 8'h00, "pin reset");
        rdchk(8'h10, 8'hff, 8'h00, "unmapped read");
        bus(1'b0, CMPCTL_IDX_PIN_DISABLE, 8'h03, 4'h0);
        rdchk(CMPCTL_IDX_PIN_DISABLE, 8'hff, 8'h00, "lane off write");
        wr(CMPCTL_IDX_CONV_CTRL_B, 8'hff);
        rdchk(CMPCTL_IDX_CONV_CTRL_B, 8'hff, 8'h4f, "convb bits");
        for (ch = 0; ch < 8; ch++) begin
            @(posedge clk);
            positive_input_pin <= ch[2];
            negative_input_pin <= ~ch[2];
            wr(CMPCTL_IDX_PIN_DISABLE, {6'h00, ch[1:0]});
            tick(2);
            check({28'h0, positive_pin_read, negative_pin_read, positive_pin_buffer_off, negative_pin_buffer_off},
                {28'h0, ch[2] & ~ch[0], ~ch[2] & ~ch[1], ch[0], ch[1]}, "pin buffers");
        end
        $display("test registers and pins done");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h04);
        tick(2);
        check({30'h0, capture_route_enable, capture_input}, 32'h2, "capture follows low");
        @(posedge clk);
        pos_lvl <= 8'h90;
        tick(6);
        check({30'h0, capture_route_enable, capture_input}, 32'h3, "capture on");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h20, 8'h20, "result high");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h10);
        tick(2);
        check({30'h0, capture_route_enable, capture_input}, 32'h0, "capture off");
        @(posedge clk);
        pos_lvl <= 8'h00;
        tick(6);
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h20, 8'h00, "result low");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h50);
        tick(6);
        check({31'h0, positive_from_bandgap}, 32'h1, "bandgap select");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h60, 8'h60, "bandgap result");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h10);
        $display("test result paths done");
        for (ch = 0; ch < 16; ch++) begin
            @(posedge clk);
            channel_low_bits <= ch[2:0];
            pos_lvl <= {ch[3:0], ch[0] ? 4'hc : 4'h4};
            wr(CMPCTL_IDX_CONV_CTRL_B, {4'h4, ch[3:0]});
            tick(6);
            check({23'h0, negative_from_mux, channel_high_bit, converter_trigger_select, negative_channel},
                {23'h0, 1'b1, ch[3], ch[2:0], ch[3:0]}, "borrowed channel");
            rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h20, {2'b00, ch[0], 5'h0}, "channel decision");
        end
        @(posedge clk);
        converter_enable <= 1'b1;
        neg_lvl <= 8'hff;
        tick(3);
        check({27'h0, negative_from_mux, negative_channel}, 32'h0, "converter owns mux");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h20, 8'h00, "pin decision");
        wr(CMPCTL_IDX_CONV_CTRL_B, 8'h0f);
        @(posedge clk);
        converter_enable <= 1'b0;
        tick(3);
        check({27'h0, negative_from_mux, negative_channel}, 32'h0, "borrow off");
        @(posedge clk);
        neg_lvl <= 8'h10;
        pos_lvl <= 8'h00;
        $display("test negative input done");
        for (ch = 0; ch < 4; ch++) begin
            wr(CMPCTL_IDX_CTRL_STATUS, 8'h10 | 8'(ch));
            @(posedge clk);
            pos_lvl <= 8'h90;
            tick(6);
            rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h10, {3'h0, ch == 0 || ch == 3, 4'h0}, "rise event");
            wr(CMPCTL_IDX_CTRL_STATUS, 8'h10 | 8'(ch));
            rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h10, 8'h00, "software clear");
            @(posedge clk);
            pos_lvl <= 8'h00;
            tick(6);
            rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h10, {3'h0, ch == 0 || ch == 2, 4'h0}, "fall event");
        end
        $display("test event modes done");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h10);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        pos_lvl <= 8'h90;
        tick(6);
        check({31'h0, irq_request}, 32'h0, "irq masked");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h08);
        tick(2);
        check({31'h0, irq_request}, 32'h1, "irq raised");
        @(posedge clk);
        global_irq_enable <= 1'b0;
        tick(2);
        check({31'h0, irq_request}, 32'h0, "global off");
        @(posedge clk);
        global_irq_enable <= 1'b1;
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
        tick(3);
        check({31'h0, irq_request}, 32'h0, "vector taken");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'h10, 8'h00, "vector clears flag");
        $display("test interrupt done");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h00);
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h90);
        tick(6);
        check({31'h0, comparator_power_off}, 32'h1, "power off");
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'hb0, 8'h80, "no event while off");
        wr(CMPCTL_IDX_CTRL_STATUS, 8'h00);
        tick(2);
        check({31'h0, comparator_power_off}, 32'h0, "power on");
        $display("test disable done");
        @(posedge clk);
        arst_n <= 1'b0;
        pos_lvl <= 8'h00;
        tick(2);
        check({26'h0, waitrequest, irq_request, comparator_power_off, positive_from_bandgap, negative_from_mux,
            capture_input}, 32'h20, "outputs in reset");
        @(posedge clk);
        arst_n <= 1'b1;
        rdchk(CMPCTL_IDX_CTRL_STATUS, 8'hff, 8'h00, "ctrl after reset");
        rdchk(CMPCTL_IDX_PIN_DISABLE, 8'hff, 8'h00, "pin after reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule : test_cmpctl_top
